// ===== inc/pgr_pkg.sv
// Package with constants and types for the power-good and local reset block.
package pgr_pkg;

   // ----------------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_PS = 4000;
   localparam int unsigned UNDER_TIME_NS = 10000;
   localparam int unsigned UNDER_CYCLES =
      (UNDER_TIME_NS * 1000) / CLK_PERIOD_PS;
   localparam int CNT_W = $clog2(UNDER_CYCLES + 2);

   // ----------------------------------------------------------------------
   // Supplies and command latch
   // ----------------------------------------------------------------------
   localparam int NUM_SUPPLIES = 4;
   localparam int CMD_W = 8;
   localparam int CMD_RESET_BIT = 3;

   typedef enum logic {
      PGR_PG_BAD,
      PGR_PG_GOOD
   } pgr_pg_state_t;

   typedef struct packed {
      logic power_good_out;
      logic board_n_a;
      logic reset_output_pin;
      logic bus_switch_enable_n;
   } pgr_status_t;

endpackage : pgr_pkg

// ===== verification/pgr_backplane_model.sv
// Backplane host and board logic driving reset-in and the command latch.
module pgr_backplane_model (
   input wire logic [8:0] req,
   output logic reset_input_pin,
   output logic [pgr_pkg::CMD_W-1:0] cmd_latch
);
   timeunit 1ns;
   timeprecision 1ps;
   // Levels only; the far side has no handshake to keep.
   assign reset_input_pin = req[8];
   assign cmd_latch = req[7:0];
endmodule : pgr_backplane_model

// ===== verification/testbench.sv
// Self-checking bench for the power-good and local reset block.
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic [3:0] supply_under = 4'h0;
   logic [8:0] req = 9'h100;
   logic rin;
   logic [7:0] cmd;
   logic [31:0] seed = 32'h43e2;
   pgr_pkg::pgr_status_t status;
   int mismatches = 0;
   int samples_checked = 0;
   pgr_backplane_model far_u (.req(req), .reset_input_pin(rin),
      .cmd_latch(cmd));
   pgr_power_good_reset dut_u (.ref_clk(ref_clk), .reset(reset),
      .supply_under(supply_under), .reset_input_pin(rin),
      .cmd_latch(cmd), .status(status));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], ^(s & 32'h80200003)};
   endfunction : lfsr
   function automatic logic exp_rst(input logic [8:0] r, input logic pg);
      return r[8] & pg & ~r[pgr_pkg::CMD_RESET_BIT];
   endfunction : exp_rst
   task automatic cmp(input string nm, input logic e, input logic s);
      samples_checked++;
      if (e !== s) begin
         mismatches++;
         $display("unexpected %s expected %b seen %b", nm, e, s);
      end
   endtask : cmp
   task automatic chk(input logic pg, input logic rst);
      cmp("power_good_out", pg, status.power_good_out);
      cmp("board_n_a", ~pg, status.board_n_a);
      cmp("reset_output_pin", rst, status.reset_output_pin);
      // Switches stay enabled (low) until power is good.
      cmp("bus_switch_enable_n", pg, status.bus_switch_enable_n);
   endtask : chk
   task automatic give_verdict();
      $display("checked %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : give_verdict
   initial begin
      forever #2 ref_clk = ~ref_clk;
   end
   initial begin
      #100us;
      mismatches++;
      give_verdict();
   end
   initial begin
      repeat (2) @(posedge ref_clk);
      reset <= 1'b0;
      repeat (3) @(posedge ref_clk);
      #1 chk(1'b1, 1'b1);
      // -------------------------------------------------------------
      // Random reset-in, latch and two-cycle supply glitches
      // -------------------------------------------------------------
      for (int i = 0; i < 300; i++) begin
         @(posedge ref_clk);
         seed = lfsr(seed);
         req <= seed[8:0];
         supply_under <= (seed[12:9] == 4'h0) ? seed[16:13] : 4'h0;
         @(posedge ref_clk);
         #1 chk(1'b1, exp_rst(req, 1'b1));
      end
      // -------------------------------------------------------------
      // Under-level of exactly the limit, then a restarted count
      // -------------------------------------------------------------
      @(posedge ref_clk);
      req <= 9'h100;
      supply_under <= 4'h0;
      @(posedge ref_clk);
      supply_under <= 4'h1;
      repeat (2500) @(posedge ref_clk);
      supply_under <= 4'h0;
      @(posedge ref_clk);
      #1 chk(1'b1, 1'b1);
      @(posedge ref_clk);
      supply_under <= 4'h8;
      repeat (2500) @(posedge ref_clk);
      #1 chk(1'b1, 1'b1);
      repeat (2) @(posedge ref_clk);
      #1 chk(1'b0, 1'b0);
      @(posedge ref_clk);
      supply_under <= 4'h0;
      repeat (3) @(posedge ref_clk);
      #1 chk(1'b1, 1'b1);
      // Reset again in mid-run: outputs return to their reset levels.
      @(posedge ref_clk);
      reset <= 1'b1;
      @(posedge ref_clk);
      #1 chk(1'b0, 1'b0);
      @(posedge ref_clk);
      reset <= 1'b0;
      repeat (2) @(posedge ref_clk);
      #1 chk(1'b1, 1'b1);
      give_verdict();
   end
endmodule : testbench

// ===== verilog/pgr_power_good_reset.sv
// Supply monitor with power-good, local reset and bus-switch enable logic.

module pgr_power_good_reset (
   ref_clk,
   reset,
   supply_under,
   reset_input_pin,
   cmd_latch,
   status
);
   input wire logic ref_clk;
   input wire logic reset;
   input wire logic [pgr_pkg::NUM_SUPPLIES-1:0] supply_under;
   input wire logic reset_input_pin;
   input wire logic [pgr_pkg::CMD_W-1:0] cmd_latch;
   output pgr_pkg::pgr_status_t status;

   // ----------------------------------------------------------------------
   // Monitor
   // ----------------------------------------------------------------------
   wire logic under_any;
   wire logic under_qualified;
   wire logic cmd_latch_reset_bit;
   pgr_pkg::pgr_pg_state_t pg_reg;
   pgr_pkg::pgr_pg_state_t pg_next;
   pgr_pkg::pgr_status_t status_next;

   assign under_any = |supply_under;
   assign cmd_latch_reset_bit = cmd_latch[pgr_pkg::CMD_RESET_BIT];

   pgr_under_filter u_filter (
      .ref_clk(ref_clk),
      .reset(reset),
      .under_any(under_any),
      .under_qualified(under_qualified)
   );

   // Power is good again one cycle after no supply is under level, once the filter count has cleared; there is no fault
   // latch here, so a drop never needs software to recover.
   assign pg_next = under_qualified ? pgr_pkg::PGR_PG_BAD :
                    (!under_any ? pgr_pkg::PGR_PG_GOOD : pg_reg);

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   // Decoded from next state so that power-good and local reset change in
   // the same cycle, with no extra register stage between them.
   wire logic pg_good_next;
   assign pg_good_next = (pg_next == pgr_pkg::PGR_PG_GOOD);
   assign status_next.power_good_out = pg_good_next;
   assign status_next.board_n_a = !pg_good_next;
   assign status_next.reset_output_pin = reset_input_pin &&
      pg_good_next && !cmd_latch_reset_bit;
   // Released only once power is good, so the bus switches keep the I/O
   // lines on their bias through insertion and any later power loss; a
   // supply that chatters around its level in under-runs of at most 2500 cycles leaves this output steady.
   assign status_next.bus_switch_enable_n = pg_good_next;

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         pg_reg <= pgr_pkg::PGR_PG_BAD;
         status <= '{power_good_out: 1'b0, board_n_a: 1'b1,
                     reset_output_pin: 1'b0, bus_switch_enable_n: 1'b0};
      end else begin
         pg_reg <= pg_next;
         status <= status_next;
      end
   end

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   // The reference counter is kept apart from the filter on purpose: a fault
   // in the filter's clear or saturation then shows up as a disagreement in
   // the timing checks instead of cancelling out.
   logic [pgr_pkg::CNT_W-1:0] low_cnt;
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         low_cnt <= '0;
      end else if (!under_any) begin
         low_cnt <= '0;
      end else if (low_cnt <= pgr_pkg::CNT_W'(pgr_pkg::UNDER_CYCLES)) begin
         low_cnt <= low_cnt + pgr_pkg::CNT_W'(1);
      end
   end

   wire logic reset_permit;
   assign reset_permit = reset_input_pin && !cmd_latch_reset_bit;

   a_pg_drop_time: assert property (
      @(posedge ref_clk) disable iff (reset)
      (low_cnt > pgr_pkg::CNT_W'(pgr_pkg::UNDER_CYCLES)) |=>
      !status.power_good_out)
      else $error("power good not dropped after under time");

   a_pg_no_early: assert property (
      @(posedge ref_clk) disable iff (reset)
      $fell(status.power_good_out) |->
      $past(low_cnt) > pgr_pkg::CNT_W'(pgr_pkg::UNDER_CYCLES))
      else $error("power good dropped too early");

   a_reset_with_pg: assert property (
      @(posedge ref_clk) disable iff (reset)
      !status.power_good_out |-> !status.reset_output_pin)
      else $error("local reset high while power bad");

   a_pg_recover: assert property (
      @(posedge ref_clk) disable iff (reset)
      !under_any ##1 !under_any |=> status.power_good_out)
      else $error("power good not restored");

   a_reset_truth: assert property (
      @(posedge ref_clk) disable iff (reset)
      ##1 status.reset_output_pin == ($past(reset_input_pin) &&
         status.power_good_out && !$past(cmd_latch_reset_bit)))
      else $error("local reset truth table broken");

   a_reset_forced: assert property (
      @(posedge ref_clk) disable iff (reset)
      (!reset_input_pin || cmd_latch_reset_bit) |=>
      !status.reset_output_pin)
      else $error("local reset not forced low");

   a_bus_enable: assert property (
      @(posedge ref_clk) disable iff (reset)
      status.bus_switch_enable_n == status.power_good_out)
      else $error("bus switch enable not tied to power good");

   a_flag_polarity: assert property (
      @(posedge ref_clk) disable iff (reset)
      status.board_n_a != status.power_good_out)
      else $error("active low power good wrong");

   a_restart: assert property (
      @(posedge ref_clk) disable iff (reset)
      status.power_good_out && !under_any ##1 under_any [*8] |->
      status.power_good_out)
      else $error("qualification did not restart");

   // ----------------------------------------------------------------------
   // Edge and truth-table checks
   // ----------------------------------------------------------------------
   a_pg_hold_bad: assert property (
      @(posedge ref_clk) disable iff (reset)
      !status.power_good_out && under_any |=> !status.power_good_out)
      else $error("power good rose while a supply stayed under");

   a_pg_short_dip: assert property (
      @(posedge ref_clk) disable iff (reset)
      status.power_good_out &&
      (low_cnt <= pgr_pkg::CNT_W'(pgr_pkg::UNDER_CYCLES)) |=>
      status.power_good_out)
      else $error("power good dropped on a short under-level");

   a_drop_needs_run: assert property (
      @(posedge ref_clk) disable iff (reset)
      $fell(status.power_good_out) |-> $past(under_any, 2))
      else $error("power good dropped with no supply under");

   a_flag_follows: assert property (
      @(posedge ref_clk) disable iff (reset)
      $fell(status.power_good_out) |-> $rose(status.board_n_a))
      else $error("active low power good did not follow");

   a_reset_drop_pg: assert property (
      @(posedge ref_clk) disable iff (reset)
      $fell(status.power_good_out) |-> !status.reset_output_pin)
      else $error("local reset not low when power good dropped");

   a_pg_rise_clean: assert property (
      @(posedge ref_clk) disable iff (reset)
      $rose(status.power_good_out) |-> !$past(under_any))
      else $error("power good rose while a supply was under");

   a_dip_keeps_reset: assert property (
      @(posedge ref_clk) disable iff (reset)
      status.power_good_out && reset_permit &&
      (low_cnt <= pgr_pkg::CNT_W'(pgr_pkg::UNDER_CYCLES)) |=>
      status.reset_output_pin)
      else $error("short under-level disturbed local reset");

   a_reset_release: assert property (
      @(posedge ref_clk) disable iff (reset)
      (reset_permit && !under_any) ##1
      (reset_permit && !under_any) |=> status.reset_output_pin)
      else $error("local reset held low with all inputs permitting");

   a_reset_rin_low: assert property (
      @(posedge ref_clk) disable iff (reset)
      !reset_input_pin |=> !status.reset_output_pin)
      else $error("local reset high while reset-in low");

   a_reset_latch_bit: assert property (
      @(posedge ref_clk) disable iff (reset)
      cmd_latch_reset_bit |=> !status.reset_output_pin)
      else $error("local reset high while latch bit set");

   a_reset_high_only: assert property (
      @(posedge ref_clk) disable iff (reset)
      status.reset_output_pin |->
      $past(reset_input_pin) && !$past(cmd_latch_reset_bit) &&
      status.power_good_out)
      else $error("local reset high without all three permits");

   a_bus_release: assert property (
      @(posedge ref_clk) disable iff (reset)
      $rose(status.power_good_out) |-> $rose(status.bus_switch_enable_n))
      else $error("bus switches not released at power good");

   a_bus_hold: assert property (
      @(posedge ref_clk) disable iff (reset)
      $fell(status.power_good_out) |-> $fell(status.bus_switch_enable_n))
      else $error("bus switches not enabled at power loss");

endmodule : pgr_power_good_reset

// ===== verilog/pgr_under_filter.sv
// Time filter that qualifies an under-level indication over a count.
module pgr_under_filter (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic under_any,
   output logic under_qualified
);

   logic [pgr_pkg::CNT_W-1:0] cnt_reg;
   logic [pgr_pkg::CNT_W-1:0] cnt_next;
   localparam logic [pgr_pkg::CNT_W-1:0] LIMIT =
      pgr_pkg::CNT_W'(pgr_pkg::UNDER_CYCLES);
   localparam logic [pgr_pkg::CNT_W-1:0] ONE = pgr_pkg::CNT_W'(1);

   // Saturating count; cleared whenever every supply is back above level.
   assign cnt_next = !under_any ? '0 :
                     (cnt_reg > LIMIT) ? cnt_reg : cnt_reg + ONE;
   assign under_qualified = (cnt_reg > LIMIT);

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         cnt_reg <= '0;
      end else begin
         cnt_reg <= cnt_next;
      end
   end

   a_filter_clear: assert property (
      @(posedge ref_clk) disable iff (reset)
      !under_any |=> (cnt_reg == '0))
      else $error("under count not cleared on recovery");

endmodule : pgr_under_filter
